// File: src/smp_port.sv
`timescale 1ns/1ps
// How it works
// - port disabled: the four pins stay general-purpose, no serial work
// - clock on bit 7, slave out 6, master out 5, select 4
// - master drives serial clock; slave takes it from remote master
// - master out on MOSI, slave out on MISO, both at once
// - select ignored: role follows master_select alone
// - bit_order 0 sends msb first, 1 sends lsb first
// - master_select 1 is master, 0 slave; slave after reset
// - clock_polarity 0 idles clock low, 1 idles it high
// - phase 0: drive at select, change trailing, sample leading
// - phase 1: drive on leading edge, sample on trailing edge
// - rate codes 00..11 divide clock by 4, 16, 64, 128
// - byte end sets done flag; irq needs both enables
// - master with select honoured: select low sets done flag
// - same case: hardware clears master_select, becomes a slave
// - done flag clears only by writing 1 to it
// - data write during a transfer sets collision flag
// - collision flag clears only by writing 1 to it
// - data register: write gives byte to send, read gives received
// - enabled master: data write starts clock and one byte
module smp_port (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_clk_en,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_port_interrupt_enable,
  input  wire logic        i_global_interrupt_enable,
  output logic             o_irq,
  input  wire logic [3:0]  i_pad_in,
  input  wire logic [3:0]  i_port_out,
  input  wire logic [3:0]  i_port_oe,
  output logic      [3:0]  o_pad_out,
  output logic      [3:0]  o_pad_oe
);

  typedef struct packed {
    logic [3:0]         sync1;
    logic [3:0]         sync2;
    logic               sck_prev;
    logic [7:0]         ctrl;
    logic [7:0]         rx_buf;
    logic               f_done;
    logic               f_write_collision_flag;
    smp_pkg::smp_state_t fsm;
    logic [6:0]         half_cnt;
    logic [4:0]         edges;
    logic               sck_q;
    logic [1:0]         samp_dly;
    logic [31:0]        prdata;
  } smp_st_t;

  smp_st_t st;
  smp_st_t next_st;

  smp_shift_if sh ();

  smp_shifter u_shifter (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .sh      (sh)
  );

  function automatic logic [6:0] half_period(input logic [1:0] rate);
    case (rate)
      2'b00:   half_period = smp_pkg::HALF_DIV4;
      2'b01:   half_period = smp_pkg::HALF_DIV16;
      2'b10:   half_period = smp_pkg::HALF_DIV64;
      default: half_period = smp_pkg::HALF_DIV128;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == smp_pkg::CTRL_OFS) || (a == smp_pkg::DATA_OFS)
             || (a == smp_pkg::FLAG_OFS);
  endfunction

  // control fields
  logic       en;
  logic       master_select;
  logic       select_ignore;
  logic       clock_polarity;
  logic       clock_phase;
  logic [1:0] rate;
  logic       sel_low;
  logic       selected;
  logic       fault;
  assign en   = st.ctrl[smp_pkg::PORT_ENABLE];
  assign master_select = st.ctrl[smp_pkg::MASTER_SELECT];
  assign select_ignore = st.ctrl[smp_pkg::SELECT_IGNORE];
  assign clock_polarity = st.ctrl[smp_pkg::CLOCK_POLARITY];
  assign clock_phase = st.ctrl[smp_pkg::CLOCK_PHASE];
  assign rate = {st.ctrl[smp_pkg::RATE_SELECT_HI],
                 st.ctrl[smp_pkg::RATE_SELECT_LO]};
  assign sel_low  = !st.sync2[smp_pkg::PAD_SEL];
  assign selected = select_ignore || sel_low;
  assign fault    = en && master_select && !select_ignore && sel_low;

  // bus strobes; a frozen clock stalls the access
  logic acc;
  logic wr;
  logic wr_ctrl;
  logic wr_data;
  logic wr_flag;
  assign acc     = i_psel && i_penable && i_clk_en;
  assign wr      = acc && i_pwrite && is_mapped(i_paddr);
  assign wr_ctrl = wr && (i_paddr == smp_pkg::CTRL_OFS);
  assign wr_data = wr && (i_paddr == smp_pkg::DATA_OFS);
  assign wr_flag = wr && (i_paddr == smp_pkg::FLAG_OFS);

  logic load_p;
  logic sample_p;
  logic drive_p;
  logic ev;
  logic lead;
  logic set_done;
  logic samp_now;
  logic [4:0] edges_inc;

  assign edges_inc = st.edges + 5'h01;

  always_comb begin
    next_st  = st;
    load_p   = 1'b0;
    sample_p = 1'b0;
    drive_p  = 1'b0;
    ev       = 1'b0;
    lead     = 1'b0;
    set_done = 1'b0;
    samp_now = 1'b0;
    if (i_clk_en) begin
      // pins from outside pass two flops first
      next_st.sync1    = i_pad_in;
      next_st.sync2    = st.sync1;
      next_st.sck_prev = st.sync2[smp_pkg::PAD_CLK];

      if (i_psel && !i_penable) begin
        case (i_paddr)
          smp_pkg::CTRL_OFS: next_st.prdata = {24'h00_0000, st.ctrl};
          smp_pkg::DATA_OFS: next_st.prdata = {24'h00_0000, st.rx_buf};
          smp_pkg::FLAG_OFS: next_st.prdata = {24'h00_0000, st.f_done,
                                               st.f_write_collision_flag, 6'h00};
          default:           next_st.prdata = 32'h0000_0000;
        endcase
      end

      if (wr_ctrl) begin
        next_st.ctrl = i_pwdata[7:0];
      end

      // data write: load when idle, else the byte is dropped
      if (wr_data) begin
        if (st.fsm != smp_pkg::SMP_IDLE) begin
          next_st.f_write_collision_flag = 1'b1;
        end else begin
          load_p = 1'b1;
          if (en && master_select && !fault) begin
            next_st.fsm      = smp_pkg::SMP_RUN;
            next_st.half_cnt = half_period(rate);
            next_st.edges    = 5'h00;
          end
        end
      end

      if (!en) begin
        next_st.fsm   = smp_pkg::SMP_IDLE;
        next_st.edges = 5'h00;
      end else if (fault) begin
        // a peer took the bus: fall back to a selected slave
        next_st.ctrl[smp_pkg::MASTER_SELECT] = 1'b0;
        set_done      = 1'b1;
        next_st.fsm   = smp_pkg::SMP_IDLE;
        next_st.edges = 5'h00;
        load_p        = 1'b0;
      // last master sample may still be on its way in
      end else if (st.fsm == smp_pkg::SMP_DONE
                   && st.samp_dly == 2'b00) begin
        set_done       = 1'b1;
        next_st.rx_buf = sh.rx_byte;
        next_st.fsm    = smp_pkg::SMP_IDLE;
        next_st.edges  = 5'h00;
      end else if (master_select) begin
        if (st.fsm == smp_pkg::SMP_RUN) begin
          if (st.half_cnt == 7'h01) begin
            ev = 1'b1;
            next_st.half_cnt = half_period(rate);
            next_st.sck_q    = !st.sck_q;
          end else begin
            next_st.half_cnt = st.half_cnt - 7'h01;
          end
        end else begin
          next_st.sck_q = clock_polarity;
        end
      end else if (!selected) begin
        // deselected slave restarts its bit count
        next_st.fsm   = smp_pkg::SMP_IDLE;
        next_st.edges = 5'h00;
      end else begin
        ev = st.sync2[smp_pkg::PAD_CLK] != st.sck_prev;
      end

      if (ev) begin
        lead          = !st.edges[0];
        next_st.edges = edges_inc;
        if (!master_select) begin
          next_st.fsm = smp_pkg::SMP_RUN;
        end
        if (edges_inc == smp_pkg::EDGES_PER_BYTE) begin
          next_st.fsm = smp_pkg::SMP_DONE;
        end
        if (clock_phase) begin
          samp_now = !lead;
          drive_p  = lead;
        end else begin
          // first bit is already out since the load
          samp_now = lead;
          drive_p  = !lead && (edges_inc != smp_pkg::EDGES_PER_BYTE);
        end
      end
      // master reads MISO two cycles late, once it has crossed the
      // synchroniser; otherwise divide-by-4 would take a stale bit
      next_st.samp_dly = {st.samp_dly[0], samp_now && master_select};
      sample_p         = master_select ? st.samp_dly[1] : samp_now;

      // set wins over a clear in the same cycle
      if (wr_flag && i_pwdata[smp_pkg::TRANSFER_DONE]) begin
        next_st.f_done = 1'b0;
      end
      if (wr_flag && i_pwdata[smp_pkg::WRITE_COLLISION]) begin
        next_st.f_write_collision_flag = 1'b0;
      end
      if (set_done) begin
        next_st.f_done = 1'b1;
      end
      if (wr_data && st.fsm != smp_pkg::SMP_IDLE) begin
        next_st.f_write_collision_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st        <= '0;
      st.ctrl   <= smp_pkg::CTRL_RST;
      st.rx_buf <= smp_pkg::DATA_RST;
      st.fsm    <= smp_pkg::SMP_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign sh.load      = load_p;
  assign sh.load_data = i_pwdata[7:0];
  assign sh.lsb_first = st.ctrl[smp_pkg::BIT_ORDER];
  assign sh.sample    = sample_p;
  assign sh.drive     = drive_p;
  // master listens on MISO, slave on MOSI
  assign sh.in_bit    = master_select ? st.sync2[smp_pkg::PAD_MISO]
                             : st.sync2[smp_pkg::PAD_MOSI];

  // pins
  always_comb begin
    o_pad_out = i_port_out;
    o_pad_oe  = i_port_oe;
    if (en) begin
      o_pad_out[smp_pkg::PAD_CLK]  = st.sck_q;
      o_pad_oe[smp_pkg::PAD_CLK]   = master_select;
      o_pad_out[smp_pkg::PAD_MOSI] = sh.out_bit;
      o_pad_oe[smp_pkg::PAD_MOSI]  = master_select;
      o_pad_out[smp_pkg::PAD_MISO] = sh.out_bit;
      o_pad_oe[smp_pkg::PAD_MISO]  = !master_select && selected;
      if (!select_ignore) begin
        // select is an input while honoured
        o_pad_out[smp_pkg::PAD_SEL] = 1'b0;
        o_pad_oe[smp_pkg::PAD_SEL]  = 1'b0;
      end
    end
  end

  assign o_irq = st.f_done && i_port_interrupt_enable
              && i_global_interrupt_enable;

  assign o_prdata  = st.prdata;
  assign o_pready  = acc;
  assign o_pslverr = acc && !is_mapped(i_paddr);

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_master_start;
    i_clk_en && wr_data && en && master_select && !fault
    && st.fsm == smp_pkg::SMP_IDLE;
  endsequence

  sequence s_running;
    st.fsm == smp_pkg::SMP_RUN;
  endsequence

  chk_start_on_write: assert property (
    s_master_start |=> s_running ##0 st.edges == 5'h00)
    else $error("data write did not start a master byte");

  chk_disabled_pins: assert property (
    !en |-> o_pad_oe == i_port_oe && o_pad_out == i_port_out)
    else $error("disabled port touched the pins");

  chk_clock_direction: assert property (
    en |-> o_pad_oe[smp_pkg::PAD_CLK] == master_select)
    else $error("serial clock direction wrong for role");

  chk_idle_polarity: assert property (
    en && master_select && st.fsm == smp_pkg::SMP_IDLE && !$past(wr_ctrl)
    |-> o_pad_out[smp_pkg::PAD_CLK] == clock_polarity)
    else $error("idle serial clock level wrong");

  chk_miso_tristate: assert property (
    en && !master_select && !select_ignore && !sel_low
    |-> !o_pad_oe[smp_pkg::PAD_MISO])
    else $error("unselected slave drives MISO");

  chk_mode_fault: assert property (
    i_clk_en && fault |=> !master_select && st.f_done
    && st.fsm == smp_pkg::SMP_IDLE)
    else $error("select low did not demote the master");

  chk_collision: assert property (
    i_clk_en && wr_data && st.fsm != smp_pkg::SMP_IDLE
    |=> st.f_write_collision_flag)
    else $error("busy write did not flag collision");

  chk_done_clear: assert property (
    i_clk_en && wr_flag && i_pwdata[smp_pkg::TRANSFER_DONE]
    && !set_done |=> !st.f_done)
    else $error("write one did not clear done flag");

  chk_done_sticky: assert property (
    i_clk_en && st.f_done && !(wr_flag
    && i_pwdata[smp_pkg::TRANSFER_DONE]) |=> st.f_done)
    else $error("done flag dropped without a clear");

  chk_byte_length: assert property (
    st.fsm == smp_pkg::SMP_DONE
    |-> st.edges == smp_pkg::EDGES_PER_BYTE)
    else $error("byte ended without sixteen clock edges");

  chk_half_period: assert property (
    i_clk_en && en && master_select && ev && !fault
    |=> st.half_cnt == half_period(rate))
    else $error("serial clock half period wrong");

  chk_irq_gate: assert property (
    $rose(st.f_done) && i_port_interrupt_enable
    && i_global_interrupt_enable |-> o_irq)
    else $error("enabled done flag raised no interrupt");

endmodule

// File: src/smp_pkg.sv
package smp_pkg;

  localparam int ADDR_W = 12;

  // register byte addresses
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] DATA_OFS = 12'h004;
  localparam logic [11:0] FLAG_OFS = 12'h008;

  // serial_port_control fields
  localparam int SELECT_IGNORE   = 7;
  localparam int PORT_ENABLE     = 6;
  localparam int BIT_ORDER       = 5;
  localparam int MASTER_SELECT   = 4;
  localparam int CLOCK_POLARITY  = 3;
  localparam int CLOCK_PHASE     = 2;
  localparam int RATE_SELECT_HI  = 1;
  localparam int RATE_SELECT_LO  = 0;

  // serial_port_flags fields
  localparam int TRANSFER_DONE   = 7;
  localparam int WRITE_COLLISION = 6;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // port bit positions 7..4 mapped to pad index 3..0
  localparam int PAD_CLK  = 3;
  localparam int PAD_MISO = 2;
  localparam int PAD_MOSI = 1;
  localparam int PAD_SEL  = 0;

  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

  // half periods of the serial clock, in system clocks
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  typedef enum logic [1:0] {
    SMP_IDLE = 2'b00,
    SMP_RUN  = 2'b01,
    SMP_DONE = 2'b11
  } smp_state_t;

endpackage

// File: src/smp_shift_if.sv
`timescale 1ns/1ps
interface smp_shift_if;
  logic       load;
  logic [7:0] load_data;
  logic       lsb_first;
  logic       sample;
  logic       drive;
  logic       in_bit;
  logic       out_bit;
  logic [7:0] rx_byte;
  modport ctrl (output load, load_data, lsb_first, sample, drive,
                in_bit, input out_bit, rx_byte);
  modport shifter (input load, load_data, lsb_first, sample, drive,
                   in_bit, output out_bit, rx_byte);
endinterface

// File: src/smp_shifter.sv
`timescale 1ns/1ps
module smp_shifter (
  input  wire logic     i_clock,
  input  wire logic     i_rst,
  smp_shift_if.shifter  sh
);

  typedef struct packed {
    logic [7:0] sr;
    logic       out_q;
  } smp_shift_st_t;

  smp_shift_st_t st;
  smp_shift_st_t next_st;

  function automatic logic pick(input logic [7:0] b, input logic lsb);
    pick = lsb ? b[0] : b[7];
  endfunction

  // sample shifts at once; the line bit is held apart so it
  // only moves on a load or a drive pulse
  always_comb begin
    next_st = st;
    if (sh.load) begin
      next_st.sr    = sh.load_data;
      next_st.out_q = pick(sh.load_data, sh.lsb_first);
    end else begin
      if (sh.sample) begin
        if (sh.lsb_first) begin
          next_st.sr = {sh.in_bit, st.sr[7:1]};
        end else begin
          next_st.sr = {st.sr[6:0], sh.in_bit};
        end
      end
      if (sh.drive) begin
        // a late master sample may land in this very cycle
        next_st.out_q = pick(next_st.sr, sh.lsb_first);
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sh.out_bit = st.out_q;
  assign sh.rx_byte = st.sr;

  chk_msb_first_shift: assert property (
    @(posedge i_clock) disable iff (i_rst)
    sh.sample && !sh.load && !sh.lsb_first
    |=> st.sr == {$past(st.sr[6:0]), $past(sh.in_bit)})
    else $error("msb first shift wrong");

  chk_lsb_first_shift: assert property (
    @(posedge i_clock) disable iff (i_rst)
    sh.sample && !sh.load && sh.lsb_first
    |=> st.sr == {$past(sh.in_bit), $past(st.sr[7:1])})
    else $error("lsb first shift wrong");

endmodule

// File: dv/smp_peer.sv
`timescale 1ns/1ps
module smp_peer (
  input  wire logic       i_sclk,
  input  wire logic       i_sel_n,
  input  wire logic       i_mosi,
  input  wire logic       i_clock_polarity,
  input  wire logic       i_clock_phase,
  input  wire logic       i_lsb,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic      [7:0] o_rx
);
  int d;
  function automatic logic pick(int k);
    return i_lsb ? i_tx[k] : i_tx[7-k];
  endfunction
  initial begin
    o_miso = 1'b0;
    o_rx   = 8'h00;
    d      = 0;
  end
  // phase 0 shows the first bit as soon as selected
  always @(negedge i_sel_n) begin
    d = 0;
    if (!i_clock_phase) o_miso = pick(0);
  end
  // released line flips, so a stale level is never read as data
  always @(posedge i_sel_n) o_miso = ~o_miso;
  always @(i_sclk) begin
    if (!i_sel_n) begin
      if ((i_sclk != i_clock_polarity) ^ i_clock_phase) begin
        o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
      end else if (d < 8) begin
        if (i_clock_phase) o_miso = pick(d);
        d = d + 1;
        if (!i_clock_phase && d < 8) o_miso = pick(d);
      end
    end
  end
endmodule

// File: dv/smp_port_bench.sv
`timescale 1ns/1ps
module smp_port_bench;
  logic        clock = 1'b0;
  logic        rst, psel, pen, pwr, ie_p, ie_g, irq, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  pad_in, port_out, port_oe, pad_out, pad_oe;
  logic        sel_ext, peer_sel_n, clock_polarity, clock_phase, lsb, miso, err, sprev;
  logic        stog, mosi_b;
  logic [7:0]  ptx, prx, tx, mtx;
  logic [1:0]  rate;
  int          n, half_seen, miscompares, check_count;
  int          hcnt = 0;

  always #25 clock = ~clock;
  // undriven clock pin rests at the idle level
  assign pad_in = (pad_oe & pad_out)
                | (~pad_oe & {clock_polarity ^ stog, miso, mosi_b, sel_ext});

  smp_port smp_port_inst (
    .i_clock(clock), .i_rst(rst), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr),
    .i_port_interrupt_enable(ie_p), .i_global_interrupt_enable(ie_g),
    .o_irq(irq), .i_pad_in(pad_in), .i_port_out(port_out),
    .i_port_oe(port_oe), .o_pad_out(pad_out), .o_pad_oe(pad_oe));

  smp_peer smp_peer_inst (
    .i_sclk(pad_in[3]), .i_sel_n(peer_sel_n), .i_mosi(pad_in[1]),
    .i_clock_polarity(clock_polarity), .i_clock_phase(clock_phase), .i_lsb(lsb), .i_tx(ptx),
    .o_miso(miso), .o_rx(prx));

  always @(posedge clock) begin
    sprev <= pad_out[3];
    if (pad_out[3] !== sprev) begin
      half_seen <= hcnt;
      hcnt      <= 1;
    end else hcnt <= hcnt + 1;
  end

  function automatic logic [31:0] half_of(logic [1:0] c);
    case (c)
      2'b00:   return 32'h0000_0002;
      2'b01:   return 32'h0000_0008;
      2'b10:   return 32'h0000_0020;
      default: return 32'h0000_0040;
    endcase
  endfunction

  function automatic logic [7:0] ctl(logic ig, logic ms, logic [1:0] r);
    return {ig, 1'b1, lsb, ms, clock_polarity, clock_phase, r};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // zero wait states expected, but the master waits for pready anyway
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock);
    pen <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clock);
      k++;
    end
    if (pready !== 1'b1) miscompares++;
    rv   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clock);
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    miscompares++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000;
    pwdata = 32'h0000_0000; ie_p = 1'b1; ie_g = 1'b1; port_out = 4'h0;
    port_oe = 4'h0; sel_ext = 1'b1; peer_sel_n = 1'b1; clock_polarity = 1'b0;
    clock_phase = 1'b0; lsb = 1'b0; ptx = 8'h00;
    stog = 1'b0;
    mosi_b = 1'b1;
    miscompares = 0;
    check_count = 0;
    void'($urandom(98));
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    apb(1'b0, smp_pkg::CTRL_OFS, 8'h00);
    chk(rv, 32'h0000_0000);
    apb(1'b0, 12'h00C, 8'h00);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    repeat (4) begin
      port_out <= 4'($urandom);
      port_oe  <= 4'($urandom);
      repeat (2) @(posedge clock);
      chk({pad_oe, pad_out}, {port_oe, port_out});
    end
    port_oe <= 4'h0;
    for (int m = 0; m < 8; m++) begin
      clock_phase <= m[0];
      clock_polarity <= m[1];
      lsb  <= m[2];
      // select high while the role is rewritten, else a mode fault
      sel_ext <= 1'b1;
      ptx  <= 8'($urandom);
      tx   = 8'($urandom);
      rate = 2'(m);
      @(posedge clock);
      // phase 1 runs with select ignored and held low: still master
      apb(1'b1, smp_pkg::CTRL_OFS, ctl(m[0], 1'b1, rate));
      sel_ext <= !m[0];
      // let the idle clock settle before the peer listens
      @(posedge clock);
      peer_sel_n <= 1'b0;
      apb(1'b1, smp_pkg::DATA_OFS, tx);
      if (m == 3) apb(1'b1, smp_pkg::DATA_OFS, ~tx);
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
        @(posedge clock);
        n++;
      end
      peer_sel_n <= 1'b1;
      chk({31'h0000_0000, irq}, 32'h0000_0001);
      chk(32'(half_seen), half_of(rate));
      chk({pad_oe[3], pad_out[3]}, {1'b1, clock_polarity});
      chk(prx, tx);
      apb(1'b0, smp_pkg::DATA_OFS, 8'h00);
      chk(rv, {24'h00_0000, ptx});
      apb(1'b0, smp_pkg::CTRL_OFS, 8'h00);
      chk(rv[7:0], ctl(m[0], 1'b1, rate));
      apb(1'b1, smp_pkg::FLAG_OFS, 8'h00);
      apb(1'b0, smp_pkg::FLAG_OFS, 8'h00);
      chk(rv[7:6], {1'b1, m == 3});
      ie_g <= 1'b0;
      repeat (2) @(posedge clock);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
      ie_g <= 1'b1;
      apb(1'b1, smp_pkg::FLAG_OFS, 8'hC0);
      apb(1'b0, smp_pkg::FLAG_OFS, 8'h00);
      chk(rv, 32'h0000_0000);
    end
    // a peer pulls select low on an idle master
    sel_ext <= 1'b1;
    clock_phase <= 1'b1;
    @(posedge clock);
    apb(1'b1, smp_pkg::CTRL_OFS, ctl(1'b0, 1'b1, 2'b00));
    sel_ext <= 1'b0;
    repeat (4) @(posedge clock);
    apb(1'b0, smp_pkg::CTRL_OFS, 8'h00);
    chk(rv[smp_pkg::MASTER_SELECT], 1'b0);
    apb(1'b0, smp_pkg::FLAG_OFS, 8'h00);
    chk(rv[smp_pkg::TRANSFER_DONE], 1'b1);
    chk(pad_oe[2], 1'b1);
    sel_ext <= 1'b1;
    repeat (4) @(posedge clock);
    chk(pad_oe[2], 1'b0);
    // slave byte: the bench plays master, phase 1, lsb first
    apb(1'b1, smp_pkg::FLAG_OFS, 8'hC0);
    sel_ext <= 1'b0;
    tx  = 8'($urandom);
    mtx = 8'($urandom);
    apb(1'b1, smp_pkg::DATA_OFS, tx);
    for (int k = 0; k < 8; k++) begin
      stog   <= 1'b1;
      mosi_b <= mtx[k];
      repeat (6) @(posedge clock);
      chk({31'h0000_0000, pad_out[2]}, {31'h0000_0000, tx[k]});
      stog <= 1'b0;
      repeat (6) @(posedge clock);
    end
    apb(1'b0, smp_pkg::FLAG_OFS, 8'h00);
    chk(rv[7], 1'b1);
    apb(1'b0, smp_pkg::DATA_OFS, 8'h00);
    chk(rv[7:0], mtx);
    sel_ext <= 1'b1;
    tally_and_finish();
  end
endmodule
